// ### irq_flag_defines.svh
// register offsets, field positions, reset values for the request flag block
`ifndef IRQ_FLAG_DEFINES_SVH
`define IRQ_FLAG_DEFINES_SVH

// ****************************************************************
// register map (8-bit data, byte addresses)
// ****************************************************************
`define ADDR_W               4
`define DATA_W               8
`define CTRL_REG_ADDR        4'h0
`define MODE_REG_ADDR        4'h1
`define CAUSE_REG_ADDR       4'h2

// ****************************************************************
// bus_control_register fields
// ****************************************************************
`define CTRL_ACK_EN_BIT      3
`define CTRL_FLAG_BIT        1
`define CTRL_RESET           8'h00

// ****************************************************************
// mode register fields
// ****************************************************************
`define MODE_MASTER_BIT      0
`define MODE_WAIT_BIT        1
`define MODE_FF_FMT_BIT      2
`define MODE_FF_FMT2_BIT     3
`define MODE_AL_IRQ_EN_BIT   4
`define MODE_STOP_MASK_BIT   5
`define MODE_RESET           8'h00

// ****************************************************************
// cause register fields (sticky while the flag is set)
// ****************************************************************
`define CAUSE_START_BIT      0
`define CAUSE_XFER_END_BIT   1
`define CAUSE_ADDR_BIT       2
`define CAUSE_ACK_BIT        3
`define CAUSE_ARB_BIT        4
`define CAUSE_STOP_BIT       5
`define CAUSE_BUFFER_BIT     6
`define CAUSE_W              7

`endif

// ### irq_flag_pkg.sv
// types shared by the request flag block
package irq_flag_pkg;

  // frame format as selected by the two first-frame format bits
  typedef enum logic [1:0] {
    FMT_I2C,
    FMT_SYNC
  } format_type;

  // configuration seen by the set logic
  typedef struct packed {
    logic master;
    logic wait_en;
    logic ff_fmt;
    logic ff_fmt2;
    logic ack_en;
    logic al_irq_en;
    logic stop_mask;
  } config_type;

  // one-cycle events from the shift engine and buffers, plus the transmit level
  typedef struct packed {
    logic start_det;
    logic first_tx_empty;
    logic clk8_fall;
    logic clk8_rise;
    logic clk9_rise;
    logic addr_after_al;
    logic ack_one;
    logic arb_lost;
    logic match_one;
    logic match_two;
    logic general_call;
    logic stop_det;
    logic error_stop;
    logic restart_det;
    logic tx_mode;
    logic tx_move;
    logic rx_move;
  } event_type;

endpackage

// ### irq_evt_if.sv
// carrier between the register side and the set logic
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_defines.svh"
interface irq_evt_if;
  irq_flag_pkg::config_type cfg;
  irq_flag_pkg::event_type  evt;
  logic                     set_req;
  logic [`CAUSE_W-1:0]      cause;

  modport regs (output cfg, output evt, input set_req, input cause);
  modport setl (input cfg, input evt, output set_req, output cause);
endinterface
`default_nettype wire

// ### irq_set_logic.sv
// set-condition qualifier for the interrupt request flag
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_defines.svh"
module irq_set_logic (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  irq_evt_if.setl   bus
);

  typedef struct packed {
    logic addr_session;
    logic gc_session;
  } set_state_type;

  set_state_type       s_q;
  set_state_type       s_d;
  logic [`CAUSE_W-1:0] c;
  logic                sync_fmt;
  logic                i2c_m;
  logic                i2c_s;

  always_comb begin
    s_d = s_q;
    c = '0;
    // both format bits high selects the clocked synchronous format
    sync_fmt = bus.cfg.ff_fmt & bus.cfg.ff_fmt2;
    i2c_m = !sync_fmt && bus.cfg.master;
    i2c_s = !sync_fmt && !bus.cfg.master;
    // ****************************************************************
    // i2c master
    // ****************************************************************
    if (i2c_m) begin
      if (bus.evt.start_det && bus.evt.first_tx_empty) c[`CAUSE_START_BIT] = 1'b1;
      if (bus.cfg.wait_en && bus.evt.clk8_fall) c[`CAUSE_XFER_END_BIT] = 1'b1;
      if (!bus.cfg.wait_en && bus.evt.clk9_rise) c[`CAUSE_XFER_END_BIT] = 1'b1;
      if (bus.evt.addr_after_al) c[`CAUSE_ADDR_BIT] = 1'b1;
      if (bus.cfg.al_irq_en && bus.evt.arb_lost) c[`CAUSE_ARB_BIT] = 1'b1;
    end
    // ****************************************************************
    // i2c slave
    // ****************************************************************
    if (i2c_s) begin
      if (bus.evt.match_one || bus.evt.match_two) begin
        c[`CAUSE_ADDR_BIT] = 1'b1;
        s_d.addr_session = 1'b1;
      end
      if (bus.evt.general_call) begin
        c[`CAUSE_ADDR_BIT] = 1'b1;
        s_d.gc_session = 1'b1;
      end
      if (s_q.addr_session && bus.evt.clk9_rise) c[`CAUSE_XFER_END_BIT] = 1'b1;
      // general call is receive only
      if (s_q.gc_session && bus.evt.clk9_rise && !bus.evt.tx_mode) begin
        c[`CAUSE_XFER_END_BIT] = 1'b1;
      end
      if (!bus.cfg.stop_mask && (bus.evt.stop_det || bus.evt.error_stop)) begin
        c[`CAUSE_STOP_BIT] = 1'b1;
      end
    end
    // a session ends at restart or stop in any mode
    if (bus.evt.restart_det || bus.evt.stop_det || bus.evt.error_stop) begin
      s_d.addr_session = 1'b0;
      s_d.gc_session = 1'b0;
    end
    if (!sync_fmt && bus.cfg.ack_en && bus.evt.ack_one) c[`CAUSE_ACK_BIT] = 1'b1;
    // ****************************************************************
    // clocked synchronous format
    // ****************************************************************
    if (sync_fmt) begin
      if (bus.evt.clk8_rise) c[`CAUSE_XFER_END_BIT] = 1'b1;
      if (bus.evt.start_det) c[`CAUSE_START_BIT] = 1'b1;
    end
    // ****************************************************************
    // any mode: start in transmit mode and buffer moves
    // ****************************************************************
    if (bus.evt.start_det && bus.evt.tx_mode && bus.evt.first_tx_empty) c[`CAUSE_START_BIT] = 1'b1;
    if (bus.evt.tx_move || bus.evt.rx_move) c[`CAUSE_BUFFER_BIT] = 1'b1;
    bus.set_req = |c;
    bus.cause = c;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ### irq_flag_top.sv
// interrupt request flag of the two-wire serial interface, with its registers
//
// Function
// - flag is bit 1 of bus_control_register, resets to 0, drives request
// - set timing depends on format bits and wait bit; set set on ack check
// - master: start seen after issue with transmit-empty for first frame sets flag
// - master with wait: set at 8th clock fall
// - master without wait: set at 9th clock rise
// - master: slave address received after arbitration loss sets flag
// - i2c format: ack check enabled and received acknowledge of 1 sets flag
// - master: arbitration lost with its enable set sets flag
// - slave: own address match sets flag, then each 9th rise until restart or stop
// - slave: general call sets flag, then each receive end until restart or stop
// - slave: stop or error stop with mask clear sets flag
// - synchronous format: 8th clock rise or start detection sets flag
// - start detected in transmit mode with transmit-empty sets flag
// - transmit or receive buffer move sets flag
// - software clear only by writing 0 after reading flag as 1
// - transfer controller data register access clears flag
// - automatic clear lets controller transfers run without the cpu
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_defines.svh"
module irq_flag_top (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  // ****************************************************************
  // register port
  // ****************************************************************
  input  wire logic [`ADDR_W-1:0] addr_i,
  input  wire logic [`DATA_W-1:0] wdata_i,
  input  wire logic               we_i,
  input  wire logic               re_i,
  output logic      [`DATA_W-1:0] rdata_o,
  // ****************************************************************
  // events from the shift engine and buffers, same clock
  // ****************************************************************
  input  wire logic               start_det_i,
  input  wire logic               first_tx_empty_i,
  input  wire logic               clk8_fall_i,
  input  wire logic               clk8_rise_i,
  input  wire logic               clk9_rise_i,
  input  wire logic               addr_after_al_i,
  input  wire logic               ack_one_i,
  input  wire logic               arb_lost_i,
  input  wire logic               match_one_i,
  input  wire logic               match_two_i,
  input  wire logic               general_call_i,
  input  wire logic               stop_det_i,
  input  wire logic               error_stop_i,
  input  wire logic               restart_det_i,
  input  wire logic               tx_mode_i,
  input  wire logic               tx_move_i,
  input  wire logic               rx_move_i,
  // ****************************************************************
  // data transfer controller access to the data register
  // ****************************************************************
  input  wire logic               dtc_access_i,
  // ****************************************************************
  // outputs
  // ****************************************************************
  output logic                    interrupt_request_flag_o,
  output logic                    ack_check_enable_o,
  output logic                    master_o,
  output logic                    wait_en_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic                flag;
    logic                read_seen;
    logic                ack_en;
    logic [`DATA_W-1:0]  mode;
    logic [`CAUSE_W-1:0] cause;
    logic [`DATA_W-1:0]  rdata;
  } top_state_type;

  top_state_type s_q;
  top_state_type s_d;
  logic          sw_clear;
  logic          hw_clear;

  irq_evt_if evt_bus ();

  // ****************************************************************
  // feed the set logic
  // ****************************************************************
  assign evt_bus.cfg.master    = s_q.mode[`MODE_MASTER_BIT];
  assign evt_bus.cfg.wait_en   = s_q.mode[`MODE_WAIT_BIT];
  assign evt_bus.cfg.ff_fmt    = s_q.mode[`MODE_FF_FMT_BIT];
  assign evt_bus.cfg.ff_fmt2   = s_q.mode[`MODE_FF_FMT2_BIT];
  assign evt_bus.cfg.ack_en    = s_q.ack_en;
  assign evt_bus.cfg.al_irq_en = s_q.mode[`MODE_AL_IRQ_EN_BIT];
  assign evt_bus.cfg.stop_mask = s_q.mode[`MODE_STOP_MASK_BIT];

  assign evt_bus.evt.start_det      = start_det_i;
  assign evt_bus.evt.first_tx_empty = first_tx_empty_i;
  assign evt_bus.evt.clk8_fall      = clk8_fall_i;
  assign evt_bus.evt.clk8_rise      = clk8_rise_i;
  assign evt_bus.evt.clk9_rise      = clk9_rise_i;
  assign evt_bus.evt.addr_after_al  = addr_after_al_i;
  assign evt_bus.evt.ack_one        = ack_one_i;
  assign evt_bus.evt.arb_lost       = arb_lost_i;
  assign evt_bus.evt.match_one      = match_one_i;
  assign evt_bus.evt.match_two      = match_two_i;
  assign evt_bus.evt.general_call   = general_call_i;
  assign evt_bus.evt.stop_det       = stop_det_i;
  assign evt_bus.evt.error_stop     = error_stop_i;
  assign evt_bus.evt.restart_det    = restart_det_i;
  assign evt_bus.evt.tx_mode        = tx_mode_i;
  assign evt_bus.evt.tx_move        = tx_move_i;
  assign evt_bus.evt.rx_move        = rx_move_i;

  irq_set_logic u_set (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .bus    (evt_bus.setl)
  );

  // ****************************************************************
  // flag, registers and read path
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    // a write of 0 counts only if the last control register read since any write saw the flag at 1
    sw_clear = we_i && (addr_i == `CTRL_REG_ADDR)
               && !wdata_i[`CTRL_FLAG_BIT] && s_q.read_seen;
    // controller access clears so chained transfers need no cpu
    hw_clear = dtc_access_i;

    if (we_i) begin
      s_d.read_seen = 1'b0;
      case (addr_i)
        `CTRL_REG_ADDR: begin
          s_d.ack_en = wdata_i[`CTRL_ACK_EN_BIT];
        end
        `MODE_REG_ADDR: begin
          s_d.mode = wdata_i;
        end
        default: begin
        end
      endcase
    end

    if (re_i) begin
      case (addr_i)
        `CTRL_REG_ADDR: begin
          s_d.rdata[`CTRL_ACK_EN_BIT] = s_q.ack_en;
          s_d.rdata[`CTRL_FLAG_BIT] = s_q.flag;
          s_d.read_seen = s_q.flag;
        end
        `MODE_REG_ADDR: begin
          s_d.rdata = s_q.mode;
        end
        `CAUSE_REG_ADDR: begin
          s_d.rdata = {1'b0, s_q.cause};
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end

    if (sw_clear || hw_clear) begin
      s_d.flag = 1'b0;
      s_d.cause = '0;
    end
    // set last so a coincident event is never lost
    if (evt_bus.set_req) begin
      s_d.flag = 1'b1;
      s_d.cause = s_d.cause | evt_bus.cause;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q.flag <= 1'b0;
      s_q.read_seen <= 1'b0;
      s_q.ack_en <= 1'(`CTRL_RESET >> `CTRL_ACK_EN_BIT);
      s_q.mode <= `MODE_RESET;
      s_q.cause <= '0;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign interrupt_request_flag_o = s_q.flag;
  assign ack_check_enable_o = s_q.ack_en;
  assign master_o = s_q.mode[`MODE_MASTER_BIT];
  assign wait_en_o = s_q.mode[`MODE_WAIT_BIT];

endmodule
`default_nettype wire

// ### irq_engine_model.sv
// shift engine stand-in: one-cycle event pulses toward the flag block
`timescale 1ns/1ps
`default_nettype none
module irq_engine_model (
  input  wire logic                 clk_i,
  input  wire logic                 fire_i,
  input  wire logic [5:0]           kind_i,
  input  wire logic                 tx_mode_i,
  output var irq_flag_pkg::event_type evt_o
);
  logic [16:0] pulse_q;
  // a pulse lasts as long as fire_i is held; the bench holds it one cycle, as the real engine does
  always_ff @(posedge clk_i) begin
    // kind bit 5 adds a start pulse so two events can coincide
    pulse_q <= fire_i ? ((17'h00001 << kind_i[4:0])
                         | {kind_i[5], 16'h0000}) : 17'h00000;
  end
  always_comb begin
    evt_o = irq_flag_pkg::event_type'(pulse_q);
    evt_o.tx_mode = tx_mode_i;
  end
endmodule
`default_nettype wire

// ### irq_flag_properties.sv
// assertion checker for the interrupt request flag block
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_defines.svh"
module irq_flag_properties (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       we_i,
  input wire logic       re_i,
  input wire logic [7:0] rdata_o,
  input wire logic       start_det_i,
  input wire logic       first_tx_empty_i,
  input wire logic       clk8_fall_i,
  input wire logic       clk8_rise_i,
  input wire logic       clk9_rise_i,
  input wire logic       addr_after_al_i,
  input wire logic       ack_one_i,
  input wire logic       arb_lost_i,
  input wire logic       match_one_i,
  input wire logic       match_two_i,
  input wire logic       general_call_i,
  input wire logic       stop_det_i,
  input wire logic       error_stop_i,
  input wire logic       tx_move_i,
  input wire logic       rx_move_i,
  input wire logic       dtc_access_i,
  input wire logic       interrupt_request_flag_o,
  input wire logic       ack_check_enable_o,
  input wire logic       master_o,
  input wire logic       wait_en_o
);
  logic [7:0] mode_q;
  logic       any_evt;
  logic       sync;
  logic       wr0;
  logic       armed_q;
  // shadow of the mode register, only the format and enable bits matter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) mode_q <= 8'h00;
    else if (we_i && addr_i == `MODE_REG_ADDR) mode_q <= wdata_i;
  end
  // shadow of the read-then-write arm: a flag read arms, any write disarms
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) armed_q <= 1'b0;
    else if (we_i) armed_q <= 1'b0;
    else if (re_i && addr_i == `CTRL_REG_ADDR)
      armed_q <= interrupt_request_flag_o;
  end
  assign sync = mode_q[2] & mode_q[3];
  assign wr0 = we_i && addr_i == `CTRL_REG_ADDR && !wdata_i[1];
  assign any_evt = start_det_i | first_tx_empty_i | clk8_fall_i |
                   clk8_rise_i | clk9_rise_i | addr_after_al_i |
                   ack_one_i | arb_lost_i | match_one_i | match_two_i |
                   general_call_i | stop_det_i | error_stop_i |
                   tx_move_i | rx_move_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_read;
    re_i && addr_i == `CTRL_REG_ADDR
      |=> rdata_o[1] == $past(interrupt_request_flag_o);
  endproperty
  property p_wait;
    master_o && wait_en_o && !sync && clk8_fall_i
      |=> interrupt_request_flag_o;
  endproperty
  property p_nowait;
    master_o && !wait_en_o && !sync && clk9_rise_i
      |=> interrupt_request_flag_o;
  endproperty
  property p_ack;
    ack_check_enable_o && ack_one_i && !sync |=> interrupt_request_flag_o;
  endproperty
  property p_arb;
    master_o && mode_q[4] && !sync && arb_lost_i
      |=> interrupt_request_flag_o;
  endproperty
  property p_stop;
    !master_o && !mode_q[5] && !sync && stop_det_i
      |=> interrupt_request_flag_o;
  endproperty
  property p_sync;
    sync && clk8_rise_i |=> interrupt_request_flag_o;
  endproperty
  property p_buf;
    tx_move_i || rx_move_i |=> interrupt_request_flag_o;
  endproperty
  property p_dtc;
    dtc_access_i && !any_evt |=> !interrupt_request_flag_o;
  endproperty
  property p_clear;
    armed_q && wr0 && !any_evt |=> !interrupt_request_flag_o;
  endproperty
  property p_hold;
    interrupt_request_flag_o && !dtc_access_i && !(wr0 && armed_q)
      |=> interrupt_request_flag_o;
  endproperty
  property p_quiet;
    !interrupt_request_flag_o && !any_evt |=> !interrupt_request_flag_o;
  endproperty
  a_read: assert property (p_read) else $error("flag readback wrong");
  a_wait: assert property (p_wait) else $error("no set at 8th fall");
  a_nowait: assert property (p_nowait) else $error("no set at 9th");
  a_ack: assert property (p_ack) else $error("no set on ack one");
  a_arb: assert property (p_arb) else $error("no set on arb loss");
  a_stop: assert property (p_stop) else $error("no set on stop");
  a_sync: assert property (p_sync) else $error("no set at sync 8th");
  a_buf: assert property (p_buf) else $error("no set on move");
  a_dtc: assert property (p_dtc) else $error("dtc did not clear");
  a_clear: assert property (p_clear) else $error("clear failed");
  a_hold: assert property (p_hold) else $error("flag lost");
  a_quiet: assert property (p_quiet) else $error("flag rose alone");
  c_nine: cover property (clk9_rise_i ##1 interrupt_request_flag_o);
  c_dtc: cover property (dtc_access_i ##1 !interrupt_request_flag_o);
  c_clear: cover property (wr0 ##1 !interrupt_request_flag_o);
endmodule
bind irq_flag_top irq_flag_properties u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
  .start_det_i(start_det_i), .first_tx_empty_i(first_tx_empty_i),
  .clk8_fall_i(clk8_fall_i), .clk8_rise_i(clk8_rise_i),
  .clk9_rise_i(clk9_rise_i), .addr_after_al_i(addr_after_al_i),
  .ack_one_i(ack_one_i), .arb_lost_i(arb_lost_i),
  .match_one_i(match_one_i), .match_two_i(match_two_i),
  .general_call_i(general_call_i), .stop_det_i(stop_det_i),
  .error_stop_i(error_stop_i), .tx_move_i(tx_move_i),
  .rx_move_i(rx_move_i), .dtc_access_i(dtc_access_i),
  .interrupt_request_flag_o(interrupt_request_flag_o),
  .ack_check_enable_o(ack_check_enable_o), .master_o(master_o),
  .wait_en_o(wait_en_o));
`default_nettype wire

// ### testbench.sv
// self-checking bench for the interrupt request flag block
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_defines.svh"
module testbench;
  localparam int NT = 32;
  logic                    clk_i = 1'b0;
  logic                    rstn_i = 1'b0;
  logic [3:0]              addr_i = 4'h0;
  logic [7:0]              wdata_i = 8'h00;
  logic                    we_i = 1'b0;
  logic                    re_i = 1'b0;
  logic                    dtc_access_i = 1'b0;
  logic                    fire = 1'b0;
  logic [5:0]              kind = 6'h00;
  logic                    tx_mode = 1'b0;
  logic [7:0]              rdata_o;
  logic                    flag;
  logic                    ack_en;
  logic                    master;
  logic                    wait_en;
  irq_flag_pkg::event_type evt;
  int                      n_mismatch = 0;
  int                      tests_run = 0;
  int                      cyc = 0;
  // {mode, ctrl, kind, expected ctrl read}
  // kind bit 5 adds a start pulse, kind bit 6 is the transmit level
  logic [31:0] tbl [NT] = '{
    32'h01000C02, 32'h03000C00, 32'h03000E02, 32'h01000E00,
    32'h0C000D02, 32'h01000D00, 32'h0C001002, 32'h01080A0A,
    32'h01000A00, 32'h00080A0A, 32'h11000902, 32'h01000900,
    32'h01000B02, 32'h01002F02, 32'h00006F02, 32'h00000502,
    32'h20000500, 32'h00000402, 32'h00000102, 32'h00000002,
    32'h00000802, 32'h00000C02, 32'h00000300, 32'h00000C00,
    32'h20000702, 32'h20000C02, 32'h20000500, 32'h20000C00,
    32'h20000602, 32'h20000C02, 32'h20000300, 32'h20000C00};
  always #50 clk_i = ~clk_i;
  irq_engine_model u_eng (.clk_i(clk_i), .fire_i(fire), .kind_i(kind),
                          .tx_mode_i(tx_mode), .evt_o(evt));
  irq_flag_top dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .start_det_i(evt.start_det), .first_tx_empty_i(evt.first_tx_empty),
    .clk8_fall_i(evt.clk8_fall), .clk8_rise_i(evt.clk8_rise),
    .clk9_rise_i(evt.clk9_rise), .addr_after_al_i(evt.addr_after_al),
    .ack_one_i(evt.ack_one), .arb_lost_i(evt.arb_lost),
    .match_one_i(evt.match_one), .match_two_i(evt.match_two),
    .general_call_i(evt.general_call), .stop_det_i(evt.stop_det),
    .error_stop_i(evt.error_stop), .restart_det_i(evt.restart_det),
    .tx_mode_i(evt.tx_mode), .tx_move_i(evt.tx_move),
    .rx_move_i(evt.rx_move), .dtc_access_i(dtc_access_i),
    .interrupt_request_flag_o(flag), .ack_check_enable_o(ack_en),
    .master_o(master), .wait_en_o(wait_en));
  task automatic results();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 chk8(rdata_o, e);
  endtask
  // kind 2 is the transmit level bit, so it fires no event at all
  task automatic pulse(input logic [5:0] k, input logic d);
    @(posedge clk_i);
    fire <= 1'b1;
    kind <= k;
    @(posedge clk_i);
    fire <= 1'b0;
    dtc_access_i <= d;
    @(posedge clk_i);
    dtc_access_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`CTRL_REG_ADDR, 8'h00);
    rd(`MODE_REG_ADDR, 8'h00);
    rd(`CAUSE_REG_ADDR, 8'h00);
    rd(4'hF, 8'h00);
    wr(`CTRL_REG_ADDR, 8'h02);
    rd(`CTRL_REG_ADDR, 8'h00);
    wr(`MODE_REG_ADDR, 8'h3F);
    rd(`MODE_REG_ADDR, 8'h3F);
    chk1(master, 1'b1);
    chk1(wait_en, 1'b1);
    // the ctrl write of each step also clears the flag armed by the previous step's read
    for (int i = 0; i < NT; i++) begin
      tx_mode <= tbl[i][14];
      wr(`CTRL_REG_ADDR, tbl[i][23:16]);
      wr(`MODE_REG_ADDR, tbl[i][31:24]);
      pulse(tbl[i][13:8], 1'b0);
      rd(`CTRL_REG_ADDR, tbl[i][7:0]);
      chk1(ack_en, tbl[i][19]);
    end
    pulse(6'h01, 1'b0);
    rd(`CAUSE_REG_ADDR, 8'h40);
    wr(`CTRL_REG_ADDR, 8'h00);
    rd(`CTRL_REG_ADDR, 8'h02);
    wr(`CTRL_REG_ADDR, 8'h02);
    wr(`CTRL_REG_ADDR, 8'h00);
    rd(`CTRL_REG_ADDR, 8'h02);
    rd(`CAUSE_REG_ADDR, 8'h40);
    wr(`CTRL_REG_ADDR, 8'h00);
    rd(`CTRL_REG_ADDR, 8'h00);
    rd(`CAUSE_REG_ADDR, 8'h00);
    pulse(6'h00, 1'b0);
    pulse(6'h02, 1'b1);
    #1 chk1(flag, 1'b0);
    pulse(6'h00, 1'b1);
    rd(`CTRL_REG_ADDR, 8'h02);
    results();
  end
endmodule
`default_nettype wire
